// ===== src/macsr_pkg.sv
// Purpose: Shared constants and types of the accumulator shift/round block
// Assumes: 41-bit accumulator, 32-bit register port, 8-bit word offsets
// Notes: Register offsets are byte addresses of aligned words
package macsr_pkg;

  localparam int ACC_W = 41;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ACC_LO = 8'h04;
  localparam logic [7:0] OFS_ACC_HI = 8'h08;
  localparam logic [7:0] OFS_VIEW_LO = 8'h0C;
  localparam logic [7:0] OFS_VIEW_HI = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  // Control field positions
  localparam int CTRL_REQ_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_CNT_LSB = 2;
  localparam int CTRL_SGN_BIT = 4;
  localparam int CTRL_RND_BIT = 5;
  localparam int CTRL_SAT_BIT = 6;
  localparam int CTRL_ALN_LSB = 8;

  // Reset values
  localparam logic [ACC_W-1:0] ACC_RESET = 41'h000_0000_0000;
  localparam logic [1:0] ALIGN_RESET = 2'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Rounding and saturation constants
  localparam logic [15:0] ROUND_HALF = 16'h8000;
  localparam logic [ACC_W-1:0] SAT_UNSIGNED = 41'h000_0000_FFFF;
  localparam logic [ACC_W-1:0] SAT_SIGNED_POS = 41'h000_0000_7FFF;
  localparam logic [ACC_W-1:0] SAT_SIGNED_NEG = 41'h1FF_FFFF_8000;

  typedef enum logic [1:0] {
    MACSR_ALIGN_NONE = 2'b00,
    MACSR_ALIGN_R1 = 2'b01,
    MACSR_ALIGN_R3 = 2'b10,
    MACSR_ALIGN_R4 = 2'b11
  } macsr_align_t;

  typedef enum logic [0:0] {
    MACSR_SH_IDLE = 1'b0,
    MACSR_SH_ARMED = 1'b1
  } macsr_shift_state_t;

  typedef struct packed {
    macsr_align_t align_sel;
    logic saturation_enable;
    logic round_enable;
    logic signed_mode_select;
    logic [1:0] multi_bit_shift_count;
    logic shift_direction_select;
  } macsr_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } macsr_bus_req_t;

endpackage

// ===== src/macsr_core.sv
// Purpose: Accumulator shifter, byte alignment and rounding read views
// Assumes: Inputs synchronous to core_clk_in; one register access a cycle
// Notes: Status flags are sampled only; this block never writes them
//
// Overview of operation
// - Writing shift request shifts the 41-bit accumulator one bit in one cycle.
// - Processor mode: shift at next edge, even while a multiply runs.
// - DMA mode: pending shift waits for the multiply to complete.
// - Shift request clears itself after the shift is done.
// - Direction bit picks left or right for single and multi-bit shifts.
// - Shifting leaves all multiplier status flags untouched.
// - Signed: left keeps bit 40, zero into bit 0; right copies bit 40.
// - Unsigned: left drops bit 40; right inserts zero at bit 40.
// - Shifts up to four bits only in DMA mode, at multiply end.
// - Count codes 0 to 3 mean shifts of one to four bits.
// - Alignment is a read view, unchanged storage, default after reset.
// - Alignment settings: none, one, three and four bytes right.
// - Vacated bytes fill zero, or all ones when signed and bit 40 set.
// - Alignment never touches status flags.
// - Rounding view rounds bits 31:16 half-to-even; storage unchanged.
// - Rounding gives two-byte right shifted result, upper bytes filled.
// - Rounding or saturation view never changes status flags.
// - Unsigned rounding adds one above half or at half with odd LSB.
// - Round enable selects rounded view, else alignment view.
// - Signed mode bit selects fill and sign extension.
// - DMA mode when any DMA channel for the unit is enabled.
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/1ns

module macsr_core (
  input wire logic core_clk_in, // System clock, 100 MHz
  input wire logic arst_n_in, // Asynchronous reset, active low
  input wire macsr_pkg::macsr_bus_req_t bus_in, // Register request
  output logic [31:0] rdata_out, // Read data, cycle after read
  input wire logic dma_chan_enabled_in, // Any unit DMA channel enabled
  input wire logic mac_busy_in, // Multiply operation in progress
  input wire logic acc_load_in, // Multiply result load, pulse
  input wire logic [40:0] acc_load_data_in, // Multiply result value
  input wire logic [7:0] status_flags_in, // Status register flags
  input wire logic overflow_in, // Soft or hard overflow flag
  output logic [40:0] acc_out, // Stored accumulator
  output logic [40:0] view_out // Registered read view for DMA
);

  localparam int W = macsr_pkg::ACC_W;

  macsr_pkg::macsr_ctrl_t ctrl;
  macsr_pkg::macsr_ctrl_t next_ctrl;
  macsr_pkg::macsr_shift_state_t sh_state;
  macsr_pkg::macsr_shift_state_t next_sh_state;
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic [W-1:0] view;
  logic [W-1:0] next_view;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic mac_done;
  logic next_mac_done;

  logic dma_mode;
  logic shift_go;
  logic [2:0] shift_amt;
  logic [W-1:0] shifted;
  logic fill;
  logic [W-1:0] align_view;
  logic [W-1:0] round_view;
  logic round_inc;
  logic [15:0] round16;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;

  // One-bit steps repeated n times; each step follows the mode's fill
  function automatic logic [40:0] acc_shift(
    input logic [40:0] a,
    input logic right,
    input logic sgn,
    input logic [2:0] n
  );
    logic [40:0] r;
    r = a;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) begin
        if (right) begin
          r = sgn ? {r[40], r[40:1]} : {1'b0, r[40:1]};
        end else begin
          r = sgn ? {r[40], r[38:0], 1'b0} : {r[39:0], 1'b0};
        end
      end
    end
    return r;
  endfunction

  assign dma_mode = dma_chan_enabled_in;
  assign wr_ctrl = bus_in.wr && (bus_in.addr == macsr_pkg::OFS_CTRL);
  assign wr_lo = bus_in.wr && (bus_in.addr == macsr_pkg::OFS_ACC_LO);
  assign wr_hi = bus_in.wr && (bus_in.addr == macsr_pkg::OFS_ACC_HI);

  // Shift engine: processor mode fires at once, DMA mode after completion
  always_comb begin
    shift_go = 1'b0;
    if (sh_state == macsr_pkg::MACSR_SH_ARMED && !acc_load_in) begin
      if (!dma_mode) begin
        shift_go = 1'b1;
      end else begin
        shift_go = mac_done && !mac_busy_in;
      end
    end
  end

  // Multi-bit count only in DMA mode; processor mode is always one bit
  assign shift_amt = dma_mode ?
    {1'b0, ctrl.multi_bit_shift_count} + 3'h1 : 3'h1;
  assign shifted = acc_shift(acc, ctrl.shift_direction_select,
    ctrl.signed_mode_select, shift_amt);

  // Read views never write the accumulator
  assign fill = ctrl.signed_mode_select && acc[40];

  always_comb begin
    case (ctrl.align_sel)
      macsr_pkg::MACSR_ALIGN_NONE: align_view = acc;
      macsr_pkg::MACSR_ALIGN_R1: align_view = {{9{fill}}, acc[39:8]};
      macsr_pkg::MACSR_ALIGN_R3: align_view = {{25{fill}}, acc[39:24]};
      macsr_pkg::MACSR_ALIGN_R4: align_view = {{33{fill}}, acc[39:32]};
      default: align_view = acc;
    endcase
  end

  assign round_inc = (acc[15:0] > macsr_pkg::ROUND_HALF) ||
    ((acc[15:0] == macsr_pkg::ROUND_HALF) && acc[16]);
  assign round16 = acc[31:16] + {15'h0000, round_inc};

  always_comb begin
    round_view = {{25{fill}}, round16};
    if (ctrl.saturation_enable) begin
      if (!ctrl.signed_mode_select) begin
        if (overflow_in) begin
          round_view = macsr_pkg::SAT_UNSIGNED;
        end
      end else if (overflow_in || (acc[31] ^ round16[15])) begin
        round_view = acc[39] ? macsr_pkg::SAT_SIGNED_NEG :
          macsr_pkg::SAT_SIGNED_POS;
      end
    end
  end

  always_comb begin
    next_view = ctrl.round_enable ? round_view : align_view;
  end

  // Next state of accumulator, control and shift engine
  always_comb begin
    next_acc = acc;
    next_ctrl = ctrl;
    next_sh_state = sh_state;
    next_mac_done = acc_load_in;
    if (acc_load_in) begin
      next_acc = acc_load_data_in;
    end else if (shift_go) begin
      next_acc = shifted;
    end else if (wr_lo) begin
      next_acc = {acc[40:32], bus_in.wdata};
    end else if (wr_hi) begin
      next_acc = {bus_in.wdata[8:0], acc[31:0]};
    end
    if (shift_go) begin
      next_sh_state = macsr_pkg::MACSR_SH_IDLE;
    end
    if (wr_ctrl) begin
      next_ctrl.shift_direction_select =
        bus_in.wdata[macsr_pkg::CTRL_DIR_BIT];
      next_ctrl.multi_bit_shift_count =
        bus_in.wdata[macsr_pkg::CTRL_CNT_LSB +: 2];
      next_ctrl.signed_mode_select = bus_in.wdata[macsr_pkg::CTRL_SGN_BIT];
      next_ctrl.round_enable = bus_in.wdata[macsr_pkg::CTRL_RND_BIT];
      next_ctrl.saturation_enable = bus_in.wdata[macsr_pkg::CTRL_SAT_BIT];
      next_ctrl.align_sel =
        macsr_pkg::macsr_align_t'(bus_in.wdata[macsr_pkg::CTRL_ALN_LSB +: 2]);
      // A new request in the clearing cycle stays armed
      if (bus_in.wdata[macsr_pkg::CTRL_REQ_BIT]) begin
        next_sh_state = macsr_pkg::MACSR_SH_ARMED;
      end
    end
  end

  // Register read path; unmapped offsets read zero
  always_comb begin
    next_rdata = macsr_pkg::RDATA_RESET;
    if (bus_in.rd) begin
      case (bus_in.addr)
        macsr_pkg::OFS_CTRL: begin
          next_rdata[macsr_pkg::CTRL_REQ_BIT] =
            (sh_state == macsr_pkg::MACSR_SH_ARMED);
          next_rdata[macsr_pkg::CTRL_DIR_BIT] = ctrl.shift_direction_select;
          next_rdata[macsr_pkg::CTRL_CNT_LSB +: 2] =
            ctrl.multi_bit_shift_count;
          next_rdata[macsr_pkg::CTRL_SGN_BIT] = ctrl.signed_mode_select;
          next_rdata[macsr_pkg::CTRL_RND_BIT] = ctrl.round_enable;
          next_rdata[macsr_pkg::CTRL_SAT_BIT] = ctrl.saturation_enable;
          next_rdata[macsr_pkg::CTRL_ALN_LSB +: 2] = ctrl.align_sel;
        end
        macsr_pkg::OFS_ACC_LO: next_rdata = acc[31:0];
        macsr_pkg::OFS_ACC_HI: next_rdata = {23'h000000, acc[40:32]};
        macsr_pkg::OFS_VIEW_LO: next_rdata = next_view[31:0];
        macsr_pkg::OFS_VIEW_HI: next_rdata = {23'h000000, next_view[40:32]};
        macsr_pkg::OFS_STATE: begin
          // Flags are reported as given, never modified here
          next_rdata = {16'h0000, status_flags_in, 6'h00, mac_done,
            dma_mode};
        end
        default: next_rdata = macsr_pkg::RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc <= macsr_pkg::ACC_RESET;
      ctrl <= '{align_sel: macsr_pkg::MACSR_ALIGN_NONE,
        default: 1'b0};
      sh_state <= macsr_pkg::MACSR_SH_IDLE;
      mac_done <= 1'b0;
      view <= macsr_pkg::ACC_RESET;
      rdata <= macsr_pkg::RDATA_RESET;
    end else begin
      acc <= next_acc;
      ctrl <= next_ctrl;
      sh_state <= next_sh_state;
      mac_done <= next_mac_done;
      view <= next_view;
      rdata <= next_rdata;
    end
  end

  assign acc_out = acc;
  assign view_out = view;
  assign rdata_out = rdata;

  // Checks
  AST_MCU_SHIFT_NEXT: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (sh_state == macsr_pkg::MACSR_SH_ARMED && !dma_mode && !acc_load_in)
    |=> (acc == $past(shifted)))
    else $error("processor mode shift not applied at next edge");

  AST_DMA_HOLD: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (sh_state == macsr_pkg::MACSR_SH_ARMED && dma_mode && !mac_done &&
     !acc_load_in && !wr_lo && !wr_hi) |=> $stable(acc))
    else $error("DMA mode shift applied before multiply end");

  AST_SELF_CLEAR: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (shift_go && !wr_ctrl) |=> (sh_state == macsr_pkg::MACSR_SH_IDLE))
    else $error("shift request did not clear itself");

  AST_SIGNED_LEFT: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (shift_go && ctrl.signed_mode_select && !ctrl.shift_direction_select)
    |=> (acc[40] == $past(acc[40])) && (acc[0] == 1'b0))
    else $error("signed left shift changed bit 40");

  AST_UNSIGNED_RIGHT: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (shift_go && !ctrl.signed_mode_select && ctrl.shift_direction_select)
    |=> (acc[40] == 1'b0))
    else $error("unsigned right shift did not clear bit 40");

  AST_MCU_ONE_BIT: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (shift_go && !dma_mode && !ctrl.signed_mode_select &&
     ctrl.shift_direction_select) |=> (acc == ($past(acc) >> 1)))
    else $error("processor mode shift moved more than one bit");

  AST_DMA_FOUR_BIT: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (shift_go && dma_mode && ctrl.multi_bit_shift_count == 2'h3 &&
     !ctrl.signed_mode_select && ctrl.shift_direction_select)
    |=> (acc == ($past(acc) >> 4)))
    else $error("count code three did not shift four bits");

  AST_ALIGN_FILL: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (!ctrl.round_enable && ctrl.align_sel == macsr_pkg::MACSR_ALIGN_R4 &&
     ctrl.signed_mode_select && acc[40])
    |=> (view[40:8] == {33{1'b1}}))
    else $error("signed alignment fill wrong");

  AST_ROUND_UNSIGNED: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (ctrl.round_enable && !ctrl.saturation_enable &&
     !ctrl.signed_mode_select && acc[15:0] == 16'h8000 && acc[16])
    |=> (view == {25'h0000000, $past(acc[31:16]) + 16'h0001}))
    else $error("unsigned half-even rounding wrong");

  AST_VIEW_KEEPS_ACC: assert property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    (bus_in.rd && !acc_load_in && !shift_go && !bus_in.wr) |=> $stable(acc))
    else $error("view read changed accumulator");

  COV_MCU_SHIFT: cover property (
    @(posedge core_clk_in) disable iff (!arst_n_in) shift_go && !dma_mode);
  COV_DMA_MULTI: cover property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    shift_go && dma_mode && ctrl.multi_bit_shift_count != 2'h0);
  COV_ROUND_SAT: cover property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    ctrl.round_enable && ctrl.saturation_enable && overflow_in);
  COV_ALIGN_R3: cover property (
    @(posedge core_clk_in) disable iff (!arst_n_in)
    ctrl.align_sel == macsr_pkg::MACSR_ALIGN_R3 && fill);

endmodule

// ===== tb/macsr_mac_model.sv
// Purpose: Behavioural multiply engine that drives busy and the result load
// Assumes: One multiply at a time, started by a one-cycle pulse
// Notes: Result lines carry inverted data outside the load cycle
`timescale 1ns/1ns
module macsr_mac_model #(
  parameter int LAT = 4 // Cycles from start to result load
) (
  input wire logic clk_in, // System clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic start_in, // Start pulse
  input wire logic [40:0] result_in, // Product to deliver
  output logic busy_out, // Multiply in progress
  output logic load_out, // Result load pulse
  output logic [40:0] load_data_out // Result, valid with load only
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  always_comb begin
    next_cnt = cnt;
    if (start_in) begin
      next_cnt = 8'(LAT);
    end else if (cnt != 8'h00) begin
      next_cnt = cnt - 8'h01;
    end
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
  // Busy drops in the load cycle, so a pending shift may follow it
  assign load_out = (cnt == 8'h01);
  assign busy_out = (cnt > 8'h01);
  assign load_data_out = load_out ? result_in : ~result_in;
endmodule

// ===== tb/test_mac_accumulator_shift_round.sv
// Purpose: Self-checking bench for the accumulator shift and read views
// Assumes: Register port as in the package offsets, 100 MHz clock
// Notes: Status flags tied to a fixed pattern; overflow driven for saturation
`timescale 1ns/1ns
module test_mac_accumulator_shift_round;
  logic clk, rst_n, dma, go, busy, load, ovf;
  logic [40:0] res, ldata, acc, view;
  logic [31:0] rdata;
  macsr_pkg::macsr_bus_req_t bus;
  int errors, tests_run, cycles;

  macsr_core dut (.core_clk_in(clk), .arst_n_in(rst_n), .bus_in(bus),
    .rdata_out(rdata), .dma_chan_enabled_in(dma), .mac_busy_in(busy),
    .acc_load_in(load), .acc_load_data_in(ldata),
    .status_flags_in(8'hA5), .overflow_in(ovf), .acc_out(acc),
    .view_out(view));
  macsr_mac_model #(.LAT(6)) mac (.clk_in(clk), .arst_n_in(rst_n),
    .start_in(go), .result_in(res), .busy_out(busy), .load_out(load),
    .load_data_out(ldata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [40:0] shn(logic [40:0] a, logic r, logic s,
                                      int n);
    for (int i = 0; i < n; i++) begin
      if (r) a = {s & a[40], a[40:1]};
      else a = s ? {a[40], a[38:0], 1'b0} : {a[39:0], 1'b0};
    end
    return a;
  endfunction

  function automatic logic [40:0] aln(logic [40:0] a, logic [1:0] k,
                                      logic s);
    int b = (k == 2'h0) ? 0 : (k == 2'h1) ? 8 : (k == 2'h2) ? 24 : 32;
    // Unsigned shifted views clear bit 40 first; with no alignment the value, bit 40 included, passes unchanged
    return s ? 41'($signed(a) >>> b) : (b == 0) ? a : {1'b0, a[39:0]} >> b;
  endfunction

  function automatic logic [31:0] ctl(logic q, logic d, logic [1:0] c,
                                      logic s, logic rn, logic [1:0] al);
    return {22'h0, al, 2'h0, rn, s, c, d, q};
  endfunction

  task automatic chk(string n, logic [40:0] e, logic [40:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic w(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic r(logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wacc(logic [40:0] a);
    w(macsr_pkg::OFS_ACC_LO, a[31:0]);
    w(macsr_pkg::OFS_ACC_HI, {23'h0, a[40:32]});
  endtask

  task automatic rview(output logic [40:0] v);
    logic [31:0] lo, hi;
    r(macsr_pkg::OFS_VIEW_LO, lo);
    r(macsr_pkg::OFS_VIEW_HI, hi);
    v = {hi[8:0], lo};
  endtask

  task automatic go_mac();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    r(macsr_pkg::OFS_CTRL, d);
    chk("ctrl after reset", 41'h0, {9'h0, d});
    chk("acc after reset", 41'h0, acc);
  endtask

  // Processor mode: one-bit shift at once, even with a multiply running
  task automatic t_cpu();
    logic [31:0] d;
    logic [40:0] a = 41'h140_0000_0003;
    for (int i = 0; i < 4; i++) begin
      wacc(a);
      go_mac();
      // Count field is ignored here, so a four-bit code must still give one
      w(macsr_pkg::OFS_CTRL, ctl(1'b1, i[0], 2'h3, i[1], 1'b0, 2'h0));
      @(posedge clk);
      #1 chk("busy", 41'h1, {40'h0, busy});
      chk("cpu shift", shn(a, i[0], i[1], 1), acc);
      r(macsr_pkg::OFS_CTRL, d);
      chk("request bit", 41'h0, {40'h0, d[0]});
      r(macsr_pkg::OFS_STATE, d);
      chk("flags", 41'hA5, {33'h0, d[15:8]});
      repeat (8) @(posedge clk);
    end
  endtask

  // DMA mode: armed shift waits for the load, then shifts count+1 bits
  task automatic t_dma();
    logic [31:0] d;
    logic [40:0] b;
    @(posedge clk);
    dma <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      res <= n[0] ? 41'h1F0_0F00_00F1 : 41'h0A5_5A00_0F0F;
      #1 b = acc;
      w(macsr_pkg::OFS_CTRL, ctl(1'b1, n[1], n[1:0], n[0], 1'b0, 2'h0));
      repeat (3) @(posedge clk);
      #1 chk("armed hold", b, acc);
      go_mac();
      // Sample the load pulse off the edge; the design takes it next edge
      for (int k = 0; k < 20 && !load; k++) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1 chk("loaded", res, acc);
      @(posedge clk);
      #1 chk("dma shift", shn(res, n[1], n[0], n + 1), acc);
      r(macsr_pkg::OFS_CTRL, d);
      chk("request bit", 41'h0, {40'h0, d[0]});
    end
    @(posedge clk);
    dma <= 1'b0;
  endtask

  task automatic t_align();
    logic [40:0] a = 41'h1AB_CDEF_1234;
    logic [40:0] v;
    wacc(a);
    for (int i = 0; i < 8; i++) begin
      w(macsr_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, i[2], 1'b0, i[1:0]));
      rview(v);
      chk("align view", aln(a, i[1:0], i[2]), v);
      chk("view port", aln(a, i[1:0], i[2]), view);
      chk("acc kept", a, acc);
    end
  endtask

  task automatic t_round();
    logic [40:0] t[4] = '{41'h1FF_1234_9000, 41'h1FF_1234_7FFF,
                          41'h1FF_1235_8000, 41'h1FF_1234_8000};
    logic [15:0] inc[4] = '{16'h0001, 16'h0000, 16'h0001, 16'h0000};
    logic [40:0] v;
    w(macsr_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 2'h0));
    for (int i = 0; i < 4; i++) begin
      wacc(t[i]);
      rview(v);
      chk("round view", {25'h0, t[i][31:16] + inc[i]}, v);
      chk("acc kept", t[i], acc);
    end
    w(macsr_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 2'h0));
    wacc(41'h1FF_FFFF_1234);
    rview(v);
    chk("signed round", 41'h1FF_FFFF_FFFF, v);
    // Saturation: signed sign flip, signed overflow, unsigned overflow
    w(macsr_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 2'h0) | 32'h40);
    wacc(41'h000_7FFF_8000);
    rview(v);
    chk("sat pos", macsr_pkg::SAT_SIGNED_POS, v);
    @(posedge clk);
    ovf <= 1'b1;
    wacc(41'h180_0000_0000);
    rview(v);
    chk("sat neg", macsr_pkg::SAT_SIGNED_NEG, v);
    chk("acc kept", 41'h180_0000_0000, acc);
    w(macsr_pkg::OFS_CTRL, ctl(1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 2'h0) | 32'h40);
    rview(v);
    chk("sat unsigned", macsr_pkg::SAT_UNSIGNED, v);
    @(posedge clk);
    ovf <= 1'b0;
  endtask

  task automatic final_report();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    rst_n = 1'b0;
    bus = '0;
    dma = 1'b0;
    go = 1'b0;
    ovf = 1'b0;
    res = 41'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_cpu();
    t_dma();
    t_align();
    t_round();
    final_report();
  end
endmodule
